// ==== hdl/port_select_params.svh ====
// Constants for the serial port selection and lock block.
// Assumes inclusion by bare name from hdl/ sources.
`ifndef PORT_SELECT_PARAMS_SVH
`define PORT_SELECT_PARAMS_SVH
`define ADDR_DIE_REVISION      16'hE707
`define ADDR_PORT_LOCK_CONFIG  16'hEA00
`define LOCK_BIT_POS           0
`define PORT_LOCK_CONFIG_RESET 8'h00
`define SELECT_FALL_COUNT      2'h3
`define DIE_REVISION_DEFAULT   8'h5A
`define CAPTURE_REG_COUNT      16
`endif

// ==== hdl/port_select_pkg.sv ====
// Types shared by the serial port selection and lock block.
// Assumes nothing of its surroundings.
package port_select_pkg;
  typedef enum logic [1:0] {
    SEL_IDLE = 2'b00,
    SEL_I2C  = 2'b01,
    SEL_SPI  = 2'b10
  } port_mode_e;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_s;
endpackage : port_select_pkg

// ==== hdl/capture_reg_bank.sv ====
// Small register bank holding the values that the fast capture port sends.
// Assumes synchronous writes from the metering core; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module capture_reg_bank #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 32,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Write side
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // Read side
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : capture_reg_bank
`default_nettype wire

// ==== hdl/serial_port_select_lock.sv ====
// Serial port selection, lock and routing of the shared host port pins.
// Assumes synchronous inputs; register requests arrive from the active serial slave.
`timescale 1ns/1ps
`default_nettype none
`include "port_select_params.svh"
module serial_port_select_lock
  import port_select_pkg::*;
#(
  parameter logic [7:0] DIE_REVISION = `DIE_REVISION_DEFAULT, // Arbitrary value
  parameter int         CAP_COUNT    = `CAPTURE_REG_COUNT,
  parameter int         CAP_WIDTH    = 32
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  // Shared select pin
  input  wire logic                            selectPin,
  // Register requests from each serial slave
  input  wire port_select_pkg::reg_req_s       i2cReq,
  input  wire port_select_pkg::reg_req_s       spiReq,
  output port_select_pkg::reg_rsp_s            regRsp,
  // Capture enable from configuration and capture data loading
  input  wire logic                            captureEnableReq,
  input  wire logic                            capWrEn,
  input  wire logic [$clog2(CAP_COUNT)-1:0]    capWrAddr,
  input  wire logic [CAP_WIDTH-1:0]            capWrData,
  input  wire logic [$clog2(CAP_COUNT)-1:0]    capRdAddr,
  // Status and routing outputs
  output port_select_pkg::port_mode_e          portMode,
  output logic                                 portLocked,
  output logic                                 i2cActive,
  output logic                                 spiActive,
  output logic                                 captureActive,
  output logic [CAP_WIDTH-1:0]                 captureData
);
  import port_select_pkg::*;

  localparam int CAW = $clog2(CAP_COUNT);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rst_n   <= rstMeta;
    end
  end

  // ----------------------------------------------------------------
  // Select pin edge counting
  // ----------------------------------------------------------------
  logic       selPrev;
  logic [1:0] fallCount;
  logic       locked;
  logic [7:0] lockConfig;
  port_mode_e mode;
  port_mode_e next_mode;
  logic [1:0] next_fallCount;

  wire fallEdge   = selPrev & ~selectPin;
  wire countEdge  = fallEdge & ~locked;
  wire reachedSpi = countEdge && (fallCount == (`SELECT_FALL_COUNT - 2'h1));
  wire isI2c      = (mode == SEL_I2C);
  wire isSpi      = (mode == SEL_SPI);

  // Count freezes once SPI is chosen, so it can never wrap back to zero.
  assign next_fallCount = (countEdge && !isSpi) ? fallCount + 2'h1 : fallCount;

  // ----------------------------------------------------------------
  // Port selection state
  // ----------------------------------------------------------------
  // Spurious edges before the third stay in I2C; the third always wins unless locked.
  always_comb begin
    next_mode = mode;
    case (mode)
      SEL_IDLE: begin
        if (reachedSpi) begin
          next_mode = SEL_SPI;
        end else if (selectPin) begin
          next_mode = SEL_I2C;
        end
      end
      SEL_I2C: begin
        // Locked edges are never counted, so a locked I2C port stays put.
        if (reachedSpi) begin
          next_mode = SEL_SPI;
        end
      end
      SEL_SPI: begin
        next_mode = SEL_SPI;
      end
      default: begin
        next_mode = SEL_IDLE;
      end
    endcase
  end

  // A pin held low through reset is no fall; only edges seen after release count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selPrev   <= 1'b0;
      fallCount <= 2'h0;
      mode      <= SEL_IDLE;
    end else begin
      selPrev   <= selectPin;
      fallCount <= next_fallCount;
      mode      <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Register access through the selected port
  // ----------------------------------------------------------------
  function automatic logic hits(input reg_req_s r, input logic [15:0] a);
    hits = r.addr == a;
  endfunction : hits

  // Only the active slave's requests are honoured; the idle one is ignored.
  wire reg_req_s req = isSpi ? spiReq :
                       isI2c ? i2cReq : '0;

  wire lockWrite   = req.write && hits(req, `ADDR_PORT_LOCK_CONFIG);
  wire i2cLockSet  = isI2c && lockWrite && req.wdata[`LOCK_BIT_POS];
  wire spiLockSet  = isSpi && lockWrite;
  // Lock never clears short of reset.
  wire next_locked = locked | i2cLockSet | spiLockSet;

  wire [7:0] rdMux = hits(req, `ADDR_DIE_REVISION)     ? DIE_REVISION :
                     hits(req, `ADDR_PORT_LOCK_CONFIG) ? lockConfig : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockConfig <= `PORT_LOCK_CONFIG_RESET;
      locked     <= 1'b0;
    end else begin
      if (lockWrite) begin
        lockConfig <= req.wdata;
      end
      locked <= next_locked;
    end
  end

  // One-cycle answer to every accepted request; unmapped reads give zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRsp <= '0;
    end else begin
      regRsp.valid <= req.read | req.write;
      regRsp.rdata <= req.read ? rdMux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Capture port and routing outputs
  // ----------------------------------------------------------------
  logic [CAP_WIDTH-1:0] bankData;

  capture_reg_bank #(
    .DEPTH (CAP_COUNT),
    .WIDTH (CAP_WIDTH),
    .AW    (CAW)
  ) u_bank (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (capWrEn),
    .wrAddr (capWrAddr),
    .wrData (capWrData),
    .rdAddr (capRdAddr),
    .rdData (bankData)
  );

  // Capture shares pins with SPI, so it is only allowed beside I2C.
  wire capAllowed = captureEnableReq && isI2c;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portMode   <= SEL_IDLE;
      portLocked <= 1'b0;
      i2cActive  <= 1'b0;
      spiActive  <= 1'b0;
    end else begin
      portMode   <= mode;
      portLocked <= locked;
      i2cActive  <= isI2c;
      spiActive  <= isSpi;
    end
  end

  // Capture outputs stay quiet unless the pins are free for them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captureActive <= 1'b0;
      captureData   <= '0;
    end else begin
      captureActive <= capAllowed;
      captureData   <= capAllowed ? bankData : '0;
    end
  end
endmodule : serial_port_select_lock
`default_nettype wire

// ==== verification/serial_port_select_lock_props.sv ====
// Checker for port selection, lock and routing.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "port_select_params.svh"
module serial_port_select_lock_props
  import port_select_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        arst_n,
  input wire port_select_pkg::reg_req_s   i2cReq,
  input wire port_select_pkg::reg_req_s   spiReq,
  input wire port_select_pkg::reg_rsp_s   regRsp,
  input wire logic                        captureEnableReq,
  input wire port_select_pkg::port_mode_e portMode,
  input wire logic       portLocked,
  input wire logic       i2cActive,
  input wire logic       spiActive,
  input wire logic       captureActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire i2cLk = i2cActive && portLocked;
  chk_capture_off: assert property ((!captureEnableReq)[*3] |-> !captureActive) else $error("capture on");
  chk_capture_i2c: assert property (captureActive |-> i2cActive && !spiActive) else $error("no i2c");
  chk_spi_alone: assert property (spiActive |-> !i2cActive && portMode == SEL_SPI) else $error("spi mixed");
  chk_spi_final: assert property (spiActive |=> spiActive) else $error("spi dropped");
  chk_lock_holds: assert property (portLocked |=> portLocked && $stable(portMode)) else $error("lock lost");
  chk_i2c_kept: assert property (i2cLk |=> i2cActive && !spiActive) else $error("locked i2c left");
  chk_lock_write: assert property (i2cActive && !portLocked && i2cReq.write && i2cReq.wdata[0]
    && i2cReq.addr == `ADDR_PORT_LOCK_CONFIG |-> ##[1:2] portLocked) else $error("no lock");
  chk_rsp_timing: assert property (i2cLk && (i2cReq.read || i2cReq.write) |=> regRsp.valid) else $error("no rsp");
  chk_revision_read: assert property (i2cLk && i2cReq.read && i2cReq.addr == `ADDR_DIE_REVISION
    |=> regRsp.rdata == `DIE_REVISION_DEFAULT) else $error("bad revision");
endmodule : serial_port_select_lock_props
bind serial_port_select_lock serial_port_select_lock_props u_props (
  .clk              (clk),
  .arst_n           (arst_n),
  .i2cReq           (i2cReq),
  .spiReq           (spiReq),
  .regRsp           (regRsp),
  .captureEnableReq (captureEnableReq),
  .portMode         (portMode),
  .portLocked       (portLocked),
  .i2cActive        (i2cActive),
  .spiActive        (spiActive),
  .captureActive    (captureActive)
);
`default_nettype wire

// ==== verification/host_master_model.sv ====
// Host controller model: shared select line and slave register requests.
// Assumes the bench calls its tasks; everything changes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_master_model
  import port_select_pkg::*;
(
  input  wire logic                      clk,
  input  wire port_select_pkg::reg_rsp_s regRsp,
  output var  logic                      selectPin,
  output var  port_select_pkg::reg_req_s i2cReq,
  output var  port_select_pkg::reg_req_s spiReq
);
  initial begin
    selectPin = 1'b0;
    i2cReq = '0;
    spiReq = '0;
  end
  task automatic setSel(input logic v);
    @(negedge clk);
    selectPin = v;
  endtask : setSel
  // Select line as plain output, pulsed low n times
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk);
      selectPin = 1'b0;
      @(negedge clk);
      selectPin = 1'b1;
    end
  endtask : pulse
  // SPI access is framed by a low select, so three writes give three falls
  task automatic xfer(input logic s, w, input logic [15:0] a, input logic [7:0] d, output reg_rsp_s r);
    reg_req_s q;
    q = '{w, !w, a, d};
    r = '0;
    @(negedge clk);
    if (s) spiReq = q;
    else i2cReq = q;
    selectPin = selectPin & !s;
    @(negedge clk);
    // Released fields show inverted junk, not the last value
    i2cReq = '{1'b0, 1'b0, ~a, ~d};
    spiReq = '{1'b0, 1'b0, ~a, ~d};
    selectPin = selectPin | s;
    repeat (3) begin
      if (regRsp.valid && !r.valid) r = regRsp;
      @(negedge clk);
    end
  endtask : xfer
endmodule : host_master_model
`default_nettype wire

// ==== verification/serial_port_select_lock_bench.sv ====
// Self-checking bench for port selection and lock.
// Assumes the design and host model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "port_select_params.svh"
module serial_port_select_lock_bench;
  import port_select_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, captureEnableReq = 1'b0, capWrEn = 1'b0;
  logic [3:0] capWrAddr = '0, capRdAddr = '0;
  logic [31:0] capWrData = '0, captureData;
  logic selectPin, portLocked, i2cActive, spiActive, captureActive;
  reg_req_s i2cReq, spiReq;
  reg_rsp_s regRsp, r;
  port_mode_e portMode;
  int fails = 0, n_compared = 0;
  serial_port_select_lock u_serial_port_select_lock (
    .clk              (clk),
    .arst_n           (arst_n),
    .selectPin        (selectPin),
    .i2cReq           (i2cReq),
    .spiReq           (spiReq),
    .regRsp           (regRsp),
    .captureEnableReq (captureEnableReq),
    .capWrEn          (capWrEn),
    .capWrAddr        (capWrAddr),
    .capWrData        (capWrData),
    .capRdAddr        (capRdAddr),
    .portMode         (portMode),
    .portLocked       (portLocked),
    .i2cActive        (i2cActive),
    .spiActive        (spiActive),
    .captureActive    (captureActive),
    .captureData      (captureData)
  );
  host_master_model u_host_master_model (
    .clk       (clk),
    .regRsp    (regRsp),
    .selectPin (selectPin),
    .i2cReq    (i2cReq),
    .spiReq    (spiReq)
  );
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle
  task automatic rst();
    arst_n = 1'b0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : rst
  task automatic acc(input logic s, w, input logic [15:0] a, input logic [7:0] d, input logic ev, input logic [7:0] ed);
    u_host_master_model.xfer(s, w, a, d, r);
    chk(r.valid, ev);
    if (ev && !w) chk(r.rdata, ed);
  endtask : acc
  initial begin
    rst();
    chk(portMode, SEL_IDLE);
    acc(0, 0, `ADDR_DIE_REVISION, 0, 0, 0);
    u_host_master_model.setSel(1);
    settle();
    chk({i2cActive, spiActive, captureActive, portMode}, {3'b100, SEL_I2C});
    captureEnableReq = 1'b1;
    settle();
    chk(captureActive, 1);
    acc(0, 0, `ADDR_PORT_LOCK_CONFIG, 0, 1, `PORT_LOCK_CONFIG_RESET);
    acc(0, 1, `ADDR_PORT_LOCK_CONFIG, 8'h00, 1, 0);
    chk(portLocked, 0);
    acc(0, 1, `ADDR_PORT_LOCK_CONFIG, 8'h01, 1, 0);
    chk(portLocked, 1);
    acc(0, 0, `ADDR_PORT_LOCK_CONFIG, 0, 1, 8'h01);
    u_host_master_model.pulse(3);
    settle();
    chk({i2cActive, spiActive, portMode}, {2'b10, SEL_I2C});
    acc(1, 0, `ADDR_DIE_REVISION, 0, 0, 0);
    acc(0, 1, `ADDR_DIE_REVISION, 8'hFF, 1, 0);
    acc(0, 0, `ADDR_DIE_REVISION, 0, 1, `DIE_REVISION_DEFAULT);
    for (int i = 0; i < 16; i += 15) begin
      capWrEn = 1'b1;
      capWrAddr = 4'(i);
      capWrData = 32'hC0DE0000 + i;
      @(negedge clk);
      capWrEn = 1'b0;
      capRdAddr = 4'(i);
      repeat (4) @(negedge clk);
      chk(captureData, 32'hC0DE0000 + i);
    end
    rst();
    repeat (3) acc(1, 1, 16'hEBFF, 0, 0, 0);
    settle();
    chk({i2cActive, spiActive, captureActive, portMode, portLocked}, {3'b010, SEL_SPI, 1'b0});
    acc(1, 0, `ADDR_DIE_REVISION, 0, 1, `DIE_REVISION_DEFAULT);
    acc(1, 0, 16'hEBFF, 0, 1, 8'h00);
    acc(0, 0, `ADDR_DIE_REVISION, 0, 0, 0);
    acc(1, 1, `ADDR_PORT_LOCK_CONFIG, 8'h00, 1, 0);
    chk(portLocked, 1);
    u_host_master_model.setSel(0);
    rst();
    chk({portMode, portLocked}, {SEL_IDLE, 1'b0});
    // Pin low through reset: only two real falls in these three pulses
    u_host_master_model.pulse(3);
    settle();
    chk({i2cActive, spiActive, portMode}, {2'b10, SEL_I2C});
    u_host_master_model.pulse(1);
    settle();
    chk({i2cActive, spiActive, portMode}, {2'b01, SEL_SPI});
    report_and_stop();
  end
endmodule : serial_port_select_lock_bench
`default_nettype wire
